// File: hw/fdr_channel_faults.v
`timescale 1ns/1ps
`include "fdr_consts.vh"
module fdr_channel_faults (
  input wire clk,
  input wire reset_n,
  input wire driverOn,
  input wire diagEnable,
  input wire openLoadDetect,
  input wire overloadDetect,
  input wire overtempDetect,
  input wire clearFault,
  output reg openLoadFlag,
  output reg driverFaultFlag
);
  // Latched per-channel faults; a new event beats a clear
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      openLoadFlag <= 1'b0;
      driverFaultFlag <= 1'b0;
    end else begin
      if (!driverOn && diagEnable && openLoadDetect) begin
        openLoadFlag <= 1'b1;
      end else if (clearFault) begin
        openLoadFlag <= 1'b0;
      end
      if ((driverOn && overloadDetect) || overtempDetect) begin
        driverFaultFlag <= 1'b1;
      end else if (clearFault) begin
        driverFaultFlag <= 1'b0;
      end
    end
  end
endmodule

// File: hw/fdr_diag_report.v
`timescale 1ns/1ps
`include "fdr_consts.vh"
module fdr_diag_report (
  input wire clk,
  input wire reset_n,
  input wire chip_select_n,
  input wire serialClk,
  input wire serialIn,
  input wire [7:0] driverOn,
  input wire [7:0] diagEnable,
  input wire [7:0] openLoadDetect,
  input wire [7:0] overloadDetect,
  input wire [7:0] overtempDetect,
  input wire limpHomeExit,
  input wire undervoltageExit,
  input wire lowPowerToOffExit,
  output reg serialOut,
  output reg serialOutEnable,
  output reg [15:0] commandWord,
  output reg commandValid,
  output reg [7:0] channelEnable,
  output reg [7:0] openLoadFlags,
  output reg [7:0] driverFaultFlags
);
  wire [7:0] olFlag;
  wire [7:0] dfFlag;
  reg [7:0] clearFault;
  reg csPrev;
  reg sclkPrev;
  reg [4:0] bitCount;
  reg frameOk;
  reg [15:0] shiftIn;
  reg [15:0] shiftOut;
  reg transmissionError;
  reg [15:0] next_report;
  reg [15:0] next_command;
  integer i;
  integer j;

  // Frame length check: 16 bits, then whole 8-bit extensions
  function lengthOk;
    input [4:0] count;
    begin
      lengthOk = (count == `FDR_FIRST_WORD);
    end
  endfunction

  // Per-channel fault latches
  genvar ch;
  generate
    for (ch = 0; ch < `FDR_CHANNELS; ch = ch + 1) begin : gChan
      fdr_channel_faults uFault (
        .clk(clk),
        .reset_n(reset_n),
        .driverOn(driverOn[ch]),
        .diagEnable(diagEnable[ch]),
        .openLoadDetect(openLoadDetect[ch]),
        .overloadDetect(overloadDetect[ch]),
        .overtempDetect(overtempDetect[ch]),
        .clearFault(clearFault[ch]),
        .openLoadFlag(olFlag[ch]),
        .driverFaultFlag(dfFlag[ch])
      );
    end
  endgenerate

  // Diagnostic word with error flag on top
  always @* begin
    next_report = {`FDR_WORD_BITS{1'b0}};
    for (i = 0; i < `FDR_CHANNELS; i = i + 1) begin
      next_report[2*i+1] = olFlag[i];
      next_report[2*i] = dfFlag[i];
    end
    next_report[`FDR_WORD_BITS-1] = transmissionError;
  end

  // Command word with new serial bit
  always @* begin
    next_command = {shiftIn[14:0], serialIn};
  end

  // Select edges seen on the system clock
  wire csFall;
  wire csRise;
  assign csFall = csPrev && !chip_select_n;
  assign csRise = !csPrev && chip_select_n;

  // Serial clock edges, ignored in the cycle the select falls
  wire sclkRise;
  wire sclkFall;
  assign sclkRise = !chip_select_n && !csFall && !sclkPrev && serialClk;
  assign sclkFall = !chip_select_n && !csFall && sclkPrev && !serialClk;

  // Mode exits that force the error flag
  wire modeExit;
  assign modeExit = limpHomeExit || undervoltageExit || lowPowerToOffExit;

  // Frame closes after 16 bits or 16 plus whole 8-bit words
  wire frameAccept;
  assign frameAccept = csRise && lengthOk(bitCount) && frameOk;

  // Previous-cycle samples of select and serial clock
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csPrev <= 1'b1;
      sclkPrev <= 1'b0;
    end else begin
      csPrev <= chip_select_n;
      sclkPrev <= serialClk;
    end
  end

  // Receive side: bit counter and command shifter
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCount <= `FDR_CNT_ZERO;
      frameOk <= 1'b0;
      shiftIn <= `FDR_CMD_RESET;
    end else if (csFall) begin
      bitCount <= `FDR_CNT_ZERO;
      frameOk <= 1'b0;
    end else if (sclkRise) begin
      shiftIn <= next_command;
      if (bitCount == `FDR_FIRST_WORD) begin
        bitCount <= `FDR_CNT_ONE + `FDR_NEXT_WORD;
      end else begin
        bitCount <= bitCount + `FDR_CNT_ONE;
      end
      if (bitCount == `FDR_FIRST_WORD - `FDR_CNT_ONE) begin
        frameOk <= 1'b1;
      end
    end
  end

  // Transmit side: error flag first, then report bits on falls
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftOut <= `FDR_REPORT_RESET;
      serialOut <= 1'b0;
      serialOutEnable <= 1'b0;
    end else if (csFall) begin
      shiftOut <= {next_report[14:0], 1'b0};
      serialOut <= next_report[`FDR_WORD_BITS-1];
      serialOutEnable <= 1'b1;
    end else if (sclkFall) begin
      serialOut <= shiftOut[`FDR_WORD_BITS-1];
      shiftOut <= {shiftOut[14:0], shiftIn[15]};
    end else if (csRise) begin
      serialOutEnable <= 1'b0;
    end
  end

  // Accepted command and per-channel clear strobes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      commandWord <= `FDR_CMD_RESET;
      commandValid <= 1'b0;
      clearFault <= `FDR_CLEAR_NONE;
    end else begin
      commandValid <= frameAccept;
      if (frameAccept) begin
        commandWord <= shiftIn;
      end
      for (j = 0; j < `FDR_CHANNELS; j = j + 1) begin
        clearFault[j] <= frameAccept && (shiftIn[2*j+1 -: 2] == `FDR_CMD_CLEAR);
      end
    end
  end

  // Error flag; a mode exit wins over a good frame
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      transmissionError <= 1'b0;
    end else if (modeExit) begin
      transmissionError <= 1'b1;
    end else if (csRise && !frameAccept) begin
      transmissionError <= 1'b1;
    end else if (frameAccept) begin
      transmissionError <= 1'b0;
    end
  end

  // Channel gating: driver faults hold off, open-load does not
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      channelEnable <= `FDR_FLAGS_RESET;
    end else begin
      channelEnable <= ~dfFlag;
    end
  end

  // Registered copies of the fault latches
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      openLoadFlags <= `FDR_FLAGS_RESET;
      driverFaultFlags <= `FDR_FLAGS_RESET;
    end else begin
      openLoadFlags <= olFlag;
      driverFaultFlags <= dfFlag;
    end
  end
endmodule

// File: pkg/fdr_consts.vh
`ifndef FDR_CONSTS_VH
`define FDR_CONSTS_VH
// Channel count and word size
`define FDR_CHANNELS 8
`define FDR_WORD_BITS 16
`define FDR_CNT_W 5
// Bit counter value that closes a valid 16-bit frame
`define FDR_FIRST_WORD 5'h10
// Later words in a chained frame are 8 bits long
`define FDR_NEXT_WORD 5'h08
// Command code that clears a channel's faults
`define FDR_CMD_CLEAR 2'h0
`define FDR_CMD_INPUT 2'h1
`define FDR_CMD_ON 2'h2
`define FDR_CMD_OFF 2'h3
// Reset value of the command word
`define FDR_CMD_RESET 16'hffff
// Bit counter start and step
`define FDR_CNT_ZERO 5'h00
`define FDR_CNT_ONE 5'h01
// Reset values of the report shifter and clear strobes
`define FDR_REPORT_RESET 16'h0000
`define FDR_CLEAR_NONE 8'h00
`define FDR_FLAGS_RESET 8'h00
`endif

// File: test/fdr_diag_report_sva.sv
`timescale 1ns/1ps
`include "fdr_consts.vh"
module fdr_diag_report_sva (
  input wire clk,
  input wire reset_n,
  input wire chip_select_n,
  input wire [7:0] driverOn,
  input wire [7:0] diagEnable,
  input wire [7:0] openLoadDetect,
  input wire serialOutEnable,
  input wire [15:0] commandWord,
  input wire commandValid,
  input wire [7:0] channelEnable,
  input wire [7:0] openLoadFlags,
  input wire [7:0] driverFaultFlags
);
  integer k;
  reg [7:0] clr;
  wire [7:0] olOk = ~driverOn & diagEnable & openLoadDetect;
  // Channels whose field holds the clear code
  always @* begin
    for (k = 0; k < 8; k = k + 1) clr[k] = (commandWord[2*k+:2] == `FDR_CMD_CLEAR);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_sel_on: assert property (!chip_select_n |=> serialOutEnable)
    else $error("output enable missing");
  chk_idle_off: assert property (chip_select_n |=> !serialOutEnable)
    else $error("output enable while idle");
  chk_ol_gate: assert property ((openLoadFlags & ~$past(openLoadFlags)
    & ~($past(olOk) | $past(olOk, 2))) == 8'h00) else $error("open-load set without cause");
  chk_ol_hold: assert property (!commandValid && !$past(commandValid)
    && !$past(commandValid, 2) |=> (openLoadFlags & $past(openLoadFlags)) == $past(openLoadFlags))
    else $error("open-load lost");
  chk_df_hold: assert property (!commandValid && !$past(commandValid)
    && !$past(commandValid, 2) |=> (driverFaultFlags & $past(driverFaultFlags))
    == $past(driverFaultFlags)) else $error("driver fault lost");
  chk_fault_off: assert property ((driverFaultFlags & channelEnable) == 8'h00)
    else $error("faulted channel enabled");
  chk_clear_flags: assert property (commandValid |-> ##2
    ((openLoadFlags | driverFaultFlags) & $past(clr, 2)) == 8'h00) else $error("no clear");
  chk_valid_pulse: assert property (commandValid |-> chip_select_n
    && $past(chip_select_n) ##1 !commandValid) else $error("bad command pulse");
endmodule
bind fdr_diag_report fdr_diag_report_sva i_fdr_diag_report_sva (.*);

// File: test/fdr_spi_master.sv
`timescale 1ns/1ps
module fdr_spi_master (
  input wire clk,
  input wire miso,
  output reg csN = 1'b1,
  output reg sclk = 1'b0,
  output reg mosi = 1'b0
);
  reg [15:0] rx = 16'h0000;
  // One frame of n bits, MSB first, two clocks per phase at least
  task frame(input [15:0] tx, input integer n);
    integer i;
    begin
      csN <= 1'b0;
      repeat (3) @(posedge clk);
      for (i = n - 1; i >= 0; i = i - 1) begin
        mosi <= tx[i[3:0]];
        repeat (2) @(posedge clk);
        sclk <= 1'b1;
        rx <= {rx[14:0], miso};
        repeat (2) @(posedge clk);
        sclk <= 1'b0;
        repeat (2) @(posedge clk);
      end
      csN <= 1'b1;
      mosi <= ~mosi; // Released line shows no stale value
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// File: test/test_fdr_diag_report.sv
`timescale 1ns/1ps
module test_fdr_diag_report;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [7:0] driverOn = 8'h00, diagEnable = 8'hfb, olDet = 8'h00, ovlDet = 8'h00, otDet = 8'h00;
  reg [2:0] exitPulse = 3'h0;
  wire csN, sclk, mosi, so, soEn, cmdValid;
  wire [15:0] cmdWord;
  wire [7:0] chanEn, olFlags, dfFlags;
  wire miso = soEn ? so : ~so;
  integer nErrors = 0;
  integer totalChecks = 0;
  integer k;
  fdr_diag_report i_fdr_diag_report (.clk(clk), .reset_n(reset_n), .chip_select_n(csN),
    .serialClk(sclk), .serialIn(mosi), .driverOn(driverOn), .diagEnable(diagEnable),
    .openLoadDetect(olDet), .overloadDetect(ovlDet), .overtempDetect(otDet),
    .limpHomeExit(exitPulse[0]), .undervoltageExit(exitPulse[1]),
    .lowPowerToOffExit(exitPulse[2]), .serialOut(so), .serialOutEnable(soEn),
    .commandWord(cmdWord), .commandValid(cmdValid), .channelEnable(chanEn),
    .openLoadFlags(olFlags), .driverFaultFlags(dfFlags));
  fdr_spi_master i_fdr_spi_master (.clk(clk), .miso(miso), .csN(csN), .sclk(sclk), .mosi(mosi));
  initial forever #12.5 clk = ~clk;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      totalChecks = totalChecks + 1;
      if (got !== exp) begin
        nErrors = nErrors + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Raw detector pulse of two clocks
  task det(input [7:0] ol, input [7:0] ovl, input [7:0] ot);
    begin
      {olDet, ovlDet, otDet} <= {ol, ovl, ot};
      repeat (2) @(posedge clk);
      {olDet, ovlDet, otDet} <= 24'h000000;
      repeat (4) @(posedge clk);
    end
  endtask
  task finishTest;
    begin
      $display("checks %0d mismatches %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    nErrors = nErrors + 1;
    finishTest;
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(cmdWord, 16'hffff);
    i_fdr_spi_master.frame(16'hffff, 16);
    driverOn <= 8'h02;
    det(8'h07, 8'h00, 8'h00);
    chk(olFlags, 16'h0001);
    driverOn <= 8'h06;
    det(8'h00, 8'h05, 8'h10);
    chk(dfFlags, 16'h0014);
    chk(chanEn & 8'h14, 16'h0000);
    chk(chanEn & 8'h01, 16'h0001);
    i_fdr_spi_master.frame(16'hffff, 16);
    chk(i_fdr_spi_master.rx, 16'h0112);
    $display("done fault latch");
    i_fdr_spi_master.frame(16'hfccc, 16);
    chk({olFlags, dfFlags}, 16'h0000);
    chk(cmdWord, 16'hfccc);
    i_fdr_spi_master.frame(16'hffff, 16);
    chk(i_fdr_spi_master.rx, 16'h0000);
    $display("done clear");
    i_fdr_spi_master.frame(16'h0000, 15);
    chk(cmdWord, 16'hffff);
    i_fdr_spi_master.frame(16'hffff, 16);
    chk(i_fdr_spi_master.rx, 16'h8000);
    $display("done frame error");
    for (k = 0; k < 3; k = k + 1) begin
      exitPulse <= 3'h1 << k;
      @(posedge clk);
      exitPulse <= 3'h0;
      i_fdr_spi_master.frame(16'hffff, 16);
      chk(i_fdr_spi_master.rx, 16'h8000);
    end
    $display("done mode exits");
    finishTest;
  end
endmodule
